// file: mastership_pkg.sv
package mastership_pkg;
    // Operating mode register layout
    localparam int         MODE_REG_WIDTH      = 24;
    localparam int         ASYNC_ARB_BIT       = 13;
    localparam int         BUS_CLOCK_OUT_BIT   = 14;
    localparam logic [23:0] MODE_REG_RESET     = 24'h000000;

    // Core clock and limits
    localparam int CORE_CLK_MHZ     = 20;
    localparam int DRAM_MAX_MHZ     = 100;

    // Clock output divider: eight core cycles per period
    localparam int       CLK_DIV_PHASES   = 8;
    localparam int       CLK_PHASE_WIDTH  = 3;
    localparam logic [2:0] CLK_HIGH_FIRST = 3'h0;
    localparam logic [2:0] CLK_HIGH_LAST  = 3'h3;
    // Quarter period lead: bus clock runs two phases ahead
    localparam logic [2:0] BUS_CLK_LEAD   = 3'h2;

    // Arbiter gap between withdrawing one grant and giving the next
    localparam int       SYNC_STAGES      = 2;
    localparam int       GRANT_GAP_CYCLES = SYNC_STAGES + 2;
    localparam int       GAP_WIDTH        = 3;

    typedef enum logic [1:0] {
        ST_SLAVE,
        ST_WAIT_FREE,
        ST_MASTER,
        ST_RELEASE
    } dev_state_t;

    typedef enum logic [1:0] {
        AR_IDLE,
        AR_GRANT_DEV,
        AR_GRANT_OTHER,
        AR_GAP
    } arb_state_t;
endpackage

// file: mastership_if.sv
`timescale 1ns/1ps
interface mastership_if;
    logic grant_n;
    logic request_n;
    logic dev_busy_drv;
    logic dev_busy_oe;
    logic arb_busy_drv;
    logic arb_busy_oe;
    logic bus_busy_line;
    logic core_clock_out;
    logic bus_clock_drv;
    logic bus_clock_oe;
    logic cas_n_drv;
    logic cas_oe;

    // Open-drain style line with external pull-up
    assign bus_busy_line = !((dev_busy_oe && !dev_busy_drv) || (arb_busy_oe && !arb_busy_drv));

    modport device (
        input  grant_n,
        input  bus_busy_line,
        output request_n,
        output dev_busy_drv,
        output dev_busy_oe,
        output core_clock_out,
        output bus_clock_drv,
        output bus_clock_oe,
        output cas_n_drv,
        output cas_oe
    );

    modport arbiter (
        input  request_n,
        input  bus_busy_line,
        input  core_clock_out,
        output grant_n,
        output arb_busy_drv,
        output arb_busy_oe
    );
endinterface

// file: mastership_device.sv
`timescale 1ns/1ps
// What this block and the arbiter do
// [RL1] Granted device waits for bus free
// [RL2] Grant removed: release after current cycle
// [RL3] Async bit set: synchronise grant and busy
// [RL4] Arbiter leaves gap between successive grants
// [RL5] New master drives busy while holding bus
// [RL6] Master may park holding busy asserted
// [RL7] Release busy: drive high, then float
// [RL8] Master drives active-low column strobe
// [RL9] Slave with enable clear floats strobe
// [RL10] No DRAM cycles above 100 MHz
// [RL11] Bus clock only as master with enable
// [RL12] Bus clock leads clock by quarter period
// [RL13] Request follows need, master or not
// [RL14] Reset: ignore inputs, slave, nothing driven
// [RL15] Async bit clear: sample inputs directly
module mastership_device
    import mastership_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic [MODE_REG_WIDTH-1:0] operating_mode_reg,
    input  wire logic                      dram_mastership_en,
    input  wire logic                      need_bus,
    input  wire logic                      cycle_active,
    input  wire logic                      cas_strobe,
    output      logic                      is_master,
    mastership_if.device                   link
);
    localparam logic DRAM_ALLOWED = (CORE_CLK_MHZ <= DRAM_MAX_MHZ);

    dev_state_t state;
    dev_state_t next_state;

    logic       grant_direct;
    logic       busy_direct;
    logic [SYNC_STAGES-1:0] grant_sync;
    logic [SYNC_STAGES-1:0] busy_sync;
    logic       granted;
    logic       bus_free;
    logic [CLK_PHASE_WIDTH-1:0] phase;
    logic [CLK_PHASE_WIDTH-1:0] lead_phase;
    logic       async_mode;
    logic       clk_out_en;
    logic       master_now;

    assign async_mode = operating_mode_reg[ASYNC_ARB_BIT];
    assign clk_out_en = operating_mode_reg[BUS_CLOCK_OUT_BIT];

    // Single-stage sampling of the pins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            grant_direct <= 1'b0;
            busy_direct  <= 1'b1;
        end else begin
            grant_direct <= !link.grant_n;         // [RL15]
            busy_direct  <= !link.bus_busy_line;   // [RL15]
        end
    end

    // Two-stage synchronisers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            grant_sync <= '0;
            busy_sync  <= '1;
        end else begin
            grant_sync <= {grant_sync[SYNC_STAGES-2:0], !link.grant_n};       // [RL3]
            busy_sync  <= {busy_sync[SYNC_STAGES-2:0], !link.bus_busy_line};  // [RL3]
        end
    end

    assign granted  = async_mode ? grant_sync[SYNC_STAGES-1] : grant_direct;  // [RL3] [RL15]
    assign bus_free = async_mode ? !busy_sync[SYNC_STAGES-1] : !busy_direct;  // [RL3] [RL15]

    always_comb begin
        next_state = state;
        case (state)
            ST_SLAVE: begin
                if (granted && need_bus) begin
                    next_state = bus_free ? ST_MASTER : ST_WAIT_FREE;  // [RL1] [RL5]
                end
            end
            ST_WAIT_FREE: begin
                if (!granted) begin
                    next_state = ST_SLAVE;
                end else if (bus_free) begin
                    next_state = ST_MASTER;                            // [RL1] [RL5]
                end
            end
            ST_MASTER: begin
                // Parking: stays master while grant holds, need or not
                if (!granted && !cycle_active) begin                   // [RL2] [RL6]
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                next_state = ST_SLAVE;                                 // [RL7]
            end
            default: begin
                next_state = ST_SLAVE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_SLAVE;                                         // [RL14]
        end else begin
            state <= next_state;
        end
    end

    // Decoded from next_state, not the state register, so the registered strobe and bus clock stop with mastership
    assign master_now = (next_state == ST_MASTER);                     // [RL8] [RL11]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            is_master <= 1'b0;
        end else begin
            is_master <= (next_state == ST_MASTER);
        end
    end

    // Busy line: low while master, high one cycle on release, then float
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link.dev_busy_drv <= 1'b1;                                 // [RL14]
            link.dev_busy_oe  <= 1'b0;
        end else begin
            case (next_state)
                ST_MASTER: begin
                    link.dev_busy_drv <= 1'b0;                         // [RL5] [RL6]
                    link.dev_busy_oe  <= 1'b1;
                end
                ST_RELEASE: begin
                    link.dev_busy_drv <= 1'b1;                         // [RL7]
                    link.dev_busy_oe  <= 1'b1;
                end
                default: begin
                    link.dev_busy_drv <= 1'b1;                         // [RL7]
                    link.dev_busy_oe  <= 1'b0;
                end
            endcase
        end
    end

    // Request follows internal need
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link.request_n <= 1'b1;
        end else begin
            link.request_n <= !need_bus;                               // [RL13]
        end
    end

    // Column strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link.cas_n_drv <= 1'b1;
            link.cas_oe    <= 1'b0;                                    // [RL14]
        end else begin
            link.cas_n_drv <= !(master_now && cas_strobe && DRAM_ALLOWED);  // [RL8] [RL10]
            link.cas_oe    <= master_now || dram_mastership_en;        // [RL8] [RL9]
        end
    end

    // Clock output divider and leading bus clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase <= '0;
        end else begin
            phase <= phase + 3'h1;
        end
    end

    assign lead_phase = phase + BUS_CLK_LEAD;                          // [RL12]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            link.core_clock_out <= 1'b0;
            link.bus_clock_drv  <= 1'b0;
            link.bus_clock_oe   <= 1'b0;                               // [RL14]
        end else begin
            link.core_clock_out <= (phase >= CLK_HIGH_FIRST) && (phase <= CLK_HIGH_LAST);
            link.bus_clock_drv  <= (lead_phase >= CLK_HIGH_FIRST)
                                && (lead_phase <= CLK_HIGH_LAST);      // [RL12]
            link.bus_clock_oe   <= master_now && clk_out_en;           // [RL11]
        end
    end
endmodule // mastership_device

// file: mastership_arbiter.sv
`timescale 1ns/1ps
module mastership_arbiter
    import mastership_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  nrst,
    input  wire logic  other_request,
    input  wire logic  other_busy,
    output      logic  device_granted,
    output      logic  other_granted,
    mastership_if.arbiter link
);
    arb_state_t state;
    arb_state_t next_state;

    logic [SYNC_STAGES-1:0] req_sync;
    logic [SYNC_STAGES-1:0] busy_sync;
    logic                   dev_req;
    logic [GAP_WIDTH-1:0]   gap_count;

    // Pin inputs through two flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_sync  <= '0;
            busy_sync <= '0;
        end else begin
            req_sync  <= {req_sync[SYNC_STAGES-2:0], !link.request_n};
            busy_sync <= {busy_sync[SYNC_STAGES-2:0], !link.bus_busy_line};
        end
    end

    assign dev_req = req_sync[SYNC_STAGES-1];

    always_comb begin
        next_state = state;
        case (state)
            AR_IDLE: begin
                if (dev_req) begin
                    next_state = AR_GRANT_DEV;
                end else if (other_request) begin
                    next_state = AR_GRANT_OTHER;
                end
            end
            AR_GRANT_DEV: begin
                // Device may park while nobody else asks
                if (other_request) begin
                    next_state = AR_GAP;                                   // [RL6]
                end
            end
            AR_GRANT_OTHER: begin
                if (!other_request) begin
                    next_state = AR_GAP;
                end
            end
            AR_GAP: begin
                if (gap_count == 3'(GRANT_GAP_CYCLES - 1)) begin           // [RL4]
                    next_state = AR_IDLE;
                end
            end
            default: begin
                next_state = AR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= AR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            gap_count <= '0;
        end else if (state == AR_GAP) begin
            gap_count <= gap_count + 3'h1;                                 // [RL4]
        end else begin
            gap_count <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            link.grant_n   <= 1'b1;
            device_granted <= 1'b0;
            other_granted  <= 1'b0;
        end else begin
            link.grant_n   <= !(next_state == AR_GRANT_DEV);               // [RL1]
            device_granted <= (next_state == AR_GRANT_DEV);
            other_granted  <= (next_state == AR_GRANT_OTHER);
        end
    end

    // Drives busy low on behalf of the other master
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link.arb_busy_drv <= 1'b1;
            link.arb_busy_oe  <= 1'b0;
        end else begin
            link.arb_busy_drv <= !other_busy;                              // [RL5]
            link.arb_busy_oe  <= other_busy;
        end
    end
endmodule // mastership_arbiter

// file: mastership_chk.sv
`timescale 1ns/1ps
module mastership_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic grant_n,
    input wire logic request_n,
    input wire logic dev_busy_drv,
    input wire logic dev_busy_oe,
    input wire logic bus_busy_line,
    input wire logic core_clock_out,
    input wire logic bus_clock_drv,
    input wire logic bus_clock_oe,
    input wire logic cas_n_drv,
    input wire logic cas_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire own = dev_busy_oe && !dev_busy_drv;
    sequence s_drive_high; dev_busy_oe && dev_busy_drv; endsequence
    sequence s_clk_wave; core_clock_out[*3] ##1 !core_clock_out[*4]; endsequence
    a_take_when_free: assert property ($rose(own) |-> $past(bus_busy_line))
        else $error("bus taken while busy");
    a_park_holds: assert property ((!grant_n)[*3] ##0 own |=> own)
        else $error("master dropped bus while granted");
    a_release_high: assert property (s_drive_high |=> !dev_busy_oe)
        else $error("busy driven high too long");
    a_release_order: assert property ($fell(dev_busy_oe) |-> $past(dev_busy_drv))
        else $error("busy released without high drive");
    a_cas_master: assert property (!cas_n_drv |-> cas_oe && own)
        else $error("column strobe outside mastership");
    a_cas_float: assert property (!cas_oe |-> !own)
        else $error("column strobe floated as master");
    a_bclk_master: assert property (bus_clock_oe |-> own)
        else $error("bus clock driven as slave");
    a_bclk_lead: assert property (bus_clock_oe |-> core_clock_out == $past(bus_clock_drv, 2))
        else $error("bus clock lead wrong");
    a_clk_wave_shape: assert property ($rose(core_clock_out) |=> s_clk_wave)
        else $error("clock output shape wrong");
    a_grant_gap: assert property ($rose(grant_n) |=> grant_n[*4])
        else $error("grant gap too short");
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=>
        !dev_busy_oe && !cas_oe && !bus_clock_oe && request_n && grant_n)
        else $error("outputs active in reset");
endmodule // mastership_chk

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import mastership_pkg::*;
    logic                      clk;
    logic                      nrst;
    logic [MODE_REG_WIDTH-1:0] mode;
    logic                      dram_mastership_en;
    logic                      need_bus;
    logic                      cycle_active;
    logic                      cas_strobe;
    logic                      other_request;
    logic                      other_busy;
    logic                      is_master;
    logic                      device_granted;
    logic                      other_granted;
    int                        miscompares = 0;
    int                        compares = 0;
    int                        k;

    mastership_if mastership_if_inst ();
    mastership_device mastership_device_inst (.clk(clk), .nrst(nrst),
        .operating_mode_reg(mode), .dram_mastership_en(dram_mastership_en),
        .need_bus(need_bus), .cycle_active(cycle_active), .cas_strobe(cas_strobe),
        .is_master(is_master), .link(mastership_if_inst));
    mastership_arbiter mastership_arbiter_inst (.clk(clk), .nrst(nrst),
        .other_request(other_request), .other_busy(other_busy),
        .device_granted(device_granted), .other_granted(other_granted),
        .link(mastership_if_inst));
    mastership_chk mastership_chk_inst (.clk(clk), .nrst(nrst),
        .grant_n(mastership_if_inst.grant_n), .request_n(mastership_if_inst.request_n),
        .dev_busy_drv(mastership_if_inst.dev_busy_drv),
        .dev_busy_oe(mastership_if_inst.dev_busy_oe),
        .bus_busy_line(mastership_if_inst.bus_busy_line),
        .core_clock_out(mastership_if_inst.core_clock_out),
        .bus_clock_drv(mastership_if_inst.bus_clock_drv),
        .bus_clock_oe(mastership_if_inst.bus_clock_oe),
        .cas_n_drv(mastership_if_inst.cas_n_drv), .cas_oe(mastership_if_inst.cas_oe));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_master(input logic v, input int lim);
        k = 0;
        while (is_master !== v && k < lim) begin
            step(1);
            k++;
        end
    endtask

    task automatic t_reset(input logic async);
        @(posedge clk);
        nrst <= 1'h0;
        mode <= '0;
        mode[BUS_CLOCK_OUT_BIT] <= 1'h1;
        mode[ASYNC_ARB_BIT] <= async;
        {dram_mastership_en, cycle_active, cas_strobe, other_request, other_busy} <= 5'h00;
        need_bus <= 1'h1;
        step(10);
        check(mastership_if_inst.request_n, 1'h1);
        check({mastership_if_inst.dev_busy_oe, mastership_if_inst.cas_oe}, 2'h0);
        check({mastership_if_inst.bus_clock_oe, is_master}, 2'h0);
        @(posedge clk);
        nrst <= 1'h1;
        $display("test reset done");
    endtask

    task automatic t_acquire(input logic async);
        k = 0;
        while (mastership_if_inst.grant_n !== 1'h0 && k < 20) begin
            step(1);
            k++;
        end
        wait_master(1'h1, 10);
        check(k[7:0], async ? 8'h03 : 8'h02);
        check(device_granted, 1'h1);
        check(mastership_if_inst.bus_busy_line, 1'h0);
        check(mastership_if_inst.request_n, 1'h0);
        check(mastership_if_inst.bus_clock_oe, 1'h1);
        cas_strobe <= 1'h1;
        step(2);
        check(mastership_if_inst.cas_n_drv, 1'h0);
        cas_strobe <= 1'h0;
        need_bus <= 1'h0;
        step(6);
        check(is_master, 1'h1);
        check(mastership_if_inst.request_n, 1'h1);
        $display("test acquire done");
    endtask

    task automatic t_release;
        cycle_active <= 1'h1;
        other_request <= 1'h1;
        step(8);
        check(is_master, 1'h1);
        cycle_active <= 1'h0;
        wait_master(1'h0, 6);
        check(is_master, 1'h0);
        check({mastership_if_inst.dev_busy_oe, mastership_if_inst.dev_busy_drv}, 2'h3);
        step(1);
        check({mastership_if_inst.dev_busy_oe, mastership_if_inst.bus_busy_line}, 2'h1);
        check(mastership_if_inst.cas_oe, 1'h0);
        check(mastership_if_inst.bus_clock_oe, 1'h0);
        dram_mastership_en <= 1'h1;
        step(2);
        check({mastership_if_inst.cas_oe, mastership_if_inst.cas_n_drv}, 2'h3);
        check({other_granted, device_granted}, 2'h2);
        $display("test release done");
    endtask

    task automatic t_wait_busy;
        k = 0;
        while (other_granted !== 1'h1 && k < 20) begin
            step(1);
            k++;
        end
        other_busy <= 1'h1;
        need_bus <= 1'h1;
        other_request <= 1'h0;
        step(20);
        check({mastership_if_inst.grant_n, is_master}, 2'h0);
        other_busy <= 1'h0;
        wait_master(1'h1, 6);
        check(is_master, 1'h1);
        check(mastership_if_inst.bus_busy_line, 1'h0);
        $display("test busy wait done");
    endtask

    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #(3000 * 50);
        miscompares++;
        complete_run();
    end

    initial begin
        nrst = 1'h0;
        mode = '0;
        {dram_mastership_en, need_bus, cycle_active, cas_strobe} = 4'h0;
        {other_request, other_busy} = 2'h0;
        for (int m = 0; m < 2; m++) begin
            t_reset(m[0]);
            t_acquire(m[0]);
            t_release();
            t_wait_busy();
        end
        complete_run();
    end
endmodule // testbench
